// File: hdl/usc_pkg.sv
// Package with register map, field positions, reset values and carrier types of the serial block.
package usc_pkg;

  // Register indices on the plain register port.
  localparam logic [3:0] ADDR_CSR = 4'h0;   // Control and status.
  localparam logic [3:0] ADDR_UCR = 4'h1;   // Asynchronous control, holds the flush bit.
  localparam logic [3:0] ADDR_GCR = 4'h2;   // Generic control, holds the clock phase bit.
  localparam logic [3:0] ADDR_DBUF = 4'h3;  // Shared receive and transmit data buffer.
  localparam logic [3:0] ADDR_BAUD = 4'h4;  // Rate mantissa.
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h5;  // Sticky interrupt flags.
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h6;  // Interrupt enables.

  // Bit positions in the control and status register.
  localparam int CSR_MODE = 7;     // 0 selects SPI, 1 selects UART.
  localparam int CSR_RX_EN = 6;    // Receiver enable.
  localparam int CSR_SLAVE = 5;    // 0 selects SPI master, 1 selects SPI slave.
  localparam int CSR_FRAME = 4;    // Framing error flag.
  localparam int CSR_PARITY = 3;   // Parity error flag.
  localparam int CSR_RX_BYTE = 2;  // Received byte ready.
  localparam int CSR_TX_BYTE = 1;  // Last byte transmitted.
  localparam int CSR_ACTIVE = 0;   // Busy indication, read only.

  // Flush bit in the asynchronous control register, and phase bit in generic control.
  localparam int UCR_FLUSH = 7;
  localparam int GCR_CLOCK_PHASE_BIT = 6;

  // Bit positions in the interrupt status and mask registers.
  localparam int IRQ_RX = 0;  // Receive complete.
  localparam int IRQ_TX = 1;  // Transmit complete.

  // Values after reset.
  localparam logic [7:0] RST_CSR = 8'h00;
  localparam logic [6:0] RST_UCR = 7'h02;  // High stop bit level by default.
  localparam logic [7:0] RST_GCR = 8'h00;
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_DBUF = 8'h00;
  localparam logic [1:0] RST_IRQ = 2'h0;

  // Events reported by the serial shifting engine, each a one-cycle pulse except busy.
  typedef struct packed {
    logic rx_done;     // First stop bit checked good, byte in rx data.
    logic parity_err;  // Received byte failed parity.
    logic frame_err;   // Stop bit had the wrong level.
    logic tx_start;    // Transmit complete event for the interrupt and DMA.
    logic tx_done;     // Last written byte fully shifted out.
    logic busy;        // Level: engine transmitting or receiving.
  } usc_evt_t;

  // Configuration handed to the serial shifting engine.
  typedef struct packed {
    logic mode;        // 0 SPI, 1 UART.
    logic rx_en;       // Receiver enable.
    logic slave;       // SPI slave select.
    logic [6:0] ucr;   // Asynchronous control without the flush bit.
    logic [7:0] gcr;   // Generic control.
    logic [7:0] baud;  // Rate mantissa.
  } usc_ctrl_t;

endpackage

// File: hdl/usc_ctrl.sv
// Control, status, interrupt and DMA trigger logic of one serial port instance.
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Flush stops transfer and clears data buffers.
// - Separate receive and transmit complete flags.
// - Interrupt raised only when its enable set.
// - Two DMA triggers from the same events, held off in SPI mode with clock phase one.
// - Data buffer is DMA source and destination.
// - Five port registers plus two interrupt registers per instance.
// - Bit 7 mode, bit 5 slave, reset zero.
// - Bit 6 enables UART reception.
// - Bit 4 flags bad stop bit.
// - Receive flags on first good stop bit.
// - Bit 3 flags parity failure.
// - Bit 2 shows received byte ready.
// - Bit 1 shows last byte transmitted.
// - Bit 0 read-only busy indication.
// - Status flags cleared by writing zero.
// - Flush bit reads zero, returns to idle.
module usc_ctrl #(
  parameter int INSTANCE = 0  // Port number, zero or one.
) (
  input wire logic clk_i,                        // System clock, 40 MHz.
  input wire logic resetn_i,                     // Asynchronous reset, active low.
  input wire logic [3:0] reg_addr_i,             // Register index.
  input wire logic [7:0] reg_wdata_i,            // Write data.
  input wire logic reg_we_i,                     // Write strobe.
  input wire logic reg_re_i,                     // Read strobe.
  output logic [7:0] reg_rdata_o,                // Read data, one cycle after the strobe.
  input wire usc_pkg::usc_evt_t eng_evt_i,       // Events from the shifting engine.
  input wire logic [7:0] eng_rx_data_i,          // Received byte, valid with rx_done.
  output usc_pkg::usc_ctrl_t eng_ctrl_o,         // Configuration to the shifting engine.
  output logic [7:0] tx_data_o,                  // Byte to transmit.
  output logic tx_load_o,                        // Pulse: new byte written to the buffer.
  output logic flush_o,                          // Pulse: abort and drop partial byte.
  output logic irq_o,                            // Level interrupt request.
  output logic dma_rx_trig_o,                    // Pulse: receive complete DMA trigger.
  output logic dma_tx_trig_o,                    // Pulse: transmit complete DMA trigger.
  output logic active_o                          // Busy indication.
);

  // Only two port instances exist, so any other number has no flag pair to map to.
  if (INSTANCE < 0 || INSTANCE > 1) begin : g_bad_instance
    $error("usc_ctrl: INSTANCE must be 0 or 1");
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register state.

  logic [7:0] csr_q;         // Control and status bits, active bit unused here.
  logic [6:0] ucr_q;         // Asynchronous control without flush.
  logic [7:0] gcr_q;         // Generic control.
  logic [7:0] baud_q;        // Rate mantissa.
  logic [7:0] rx_buf_q;      // Received byte half of the shared buffer.
  logic [7:0] tx_buf_q;      // Transmit half of the shared buffer.
  logic [1:0] irq_stat_q;    // Sticky interrupt flags.
  logic [1:0] irq_mask_q;    // Interrupt enables.
  logic active_q;            // Registered busy indication.
  logic tx_load_q;           // Load pulse toward the engine.
  logic flush_q;             // Flush pulse toward the engine.
  logic dma_rx_q;            // Receive trigger pulse.
  logic dma_tx_q;            // Transmit trigger pulse.
  logic [7:0] rdata_q;       // Read data register.

  // Decoded strobes.
  logic wr_csr;
  logic wr_ucr;
  logic flush_now;
  logic rx_ok;
  logic tx_ok;
  logic dma_ok;

  // A write cycle to a given index.
  function automatic logic wr_hit(input logic we, input logic [3:0] a, input logic [3:0] idx);
    wr_hit = we && (a == idx);
  endfunction

  assign wr_csr = wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_CSR);
  assign wr_ucr = wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_UCR);

  // flush request decode.
  // A one in the flush bit aborts in the same cycle; the bit itself is not stored.
  assign flush_now = wr_ucr && reg_wdata_i[usc_pkg::UCR_FLUSH];

  // receiver gating.
  // In UART mode a byte is accepted only with the receiver enabled; SPI always receives.
  // Events in the flush cycle belong to the aborted transfer and are dropped.
  assign rx_ok = eng_evt_i.rx_done && !flush_now &&
                 (!csr_q[usc_pkg::CSR_MODE] || csr_q[usc_pkg::CSR_RX_EN]);
  assign tx_ok = eng_evt_i.tx_start && !flush_now;

  // phase guard.
  // With SPI clock phase one the DMA cannot keep up with the double buffer, so the
  // triggers are held off and the CPU must service the port from the interrupt.
  assign dma_ok = csr_q[usc_pkg::CSR_MODE] || !gcr_q[usc_pkg::GCR_CLOCK_PHASE_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Control and status register.

  // status bits clear on written zero, hardware set wins.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      csr_q <= usc_pkg::RST_CSR;
    end else begin
      // Configuration bits follow software writes.
      if (wr_csr) begin
        csr_q[usc_pkg::CSR_MODE] <= reg_wdata_i[usc_pkg::CSR_MODE];
        csr_q[usc_pkg::CSR_RX_EN] <= reg_wdata_i[usc_pkg::CSR_RX_EN];
        csr_q[usc_pkg::CSR_SLAVE] <= reg_wdata_i[usc_pkg::CSR_SLAVE];
      end
      if (eng_evt_i.frame_err && !flush_now) begin
        csr_q[usc_pkg::CSR_FRAME] <= 1'b1;
      end else if (wr_csr && !reg_wdata_i[usc_pkg::CSR_FRAME]) begin
        csr_q[usc_pkg::CSR_FRAME] <= 1'b0;
      end
      if (eng_evt_i.parity_err && !flush_now) begin
        csr_q[usc_pkg::CSR_PARITY] <= 1'b1;
      end else if (wr_csr && !reg_wdata_i[usc_pkg::CSR_PARITY]) begin
        csr_q[usc_pkg::CSR_PARITY] <= 1'b0;
      end
      // byte ready on first good stop bit.
      if (rx_ok) begin
        csr_q[usc_pkg::CSR_RX_BYTE] <= 1'b1;
      end else if ((wr_csr && !reg_wdata_i[usc_pkg::CSR_RX_BYTE]) || flush_now) begin
        csr_q[usc_pkg::CSR_RX_BYTE] <= 1'b0;
      end
      if (eng_evt_i.tx_done && !flush_now) begin
        csr_q[usc_pkg::CSR_TX_BYTE] <= 1'b1;
      end else if (wr_csr && !reg_wdata_i[usc_pkg::CSR_TX_BYTE]) begin
        csr_q[usc_pkg::CSR_TX_BYTE] <= 1'b0;
      end
      // The active bit lives in its own register.
      csr_q[usc_pkg::CSR_ACTIVE] <= 1'b0;
    end
  end

  // Other configuration registers, written whole.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ucr_q <= usc_pkg::RST_UCR;
      gcr_q <= usc_pkg::RST_GCR;
      baud_q <= usc_pkg::RST_BAUD;
    end else begin
      if (wr_ucr) begin
        ucr_q <= reg_wdata_i[6:0];
      end
      if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_GCR)) begin
        gcr_q <= reg_wdata_i;
      end
      if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_BAUD)) begin
        baud_q <= reg_wdata_i;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Shared data buffer.

  // buffer halves for DMA and CPU.
  // flush empties both halves.
  // Reads return the received byte; writes fill the transmit half and start the engine.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_buf_q <= usc_pkg::RST_DBUF;
      tx_buf_q <= usc_pkg::RST_DBUF;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= 1'b0;
      if (flush_now) begin
        rx_buf_q <= usc_pkg::RST_DBUF;
        tx_buf_q <= usc_pkg::RST_DBUF;
      end else begin
        if (rx_ok) begin
          rx_buf_q <= eng_rx_data_i;
        end
        if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_DBUF)) begin
          tx_buf_q <= reg_wdata_i;
          tx_load_q <= 1'b1;
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Abort and activity.

  // flush returns the unit to idle.
  // active drops with the flush.
  // The engine still reports busy in the cycle of the pulse and drops it on the next edge;
  // the flush_q term keeps active low over that window.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flush_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      flush_q <= flush_now;
      active_q <= eng_evt_i.busy && !flush_now && !flush_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt flags and enables.

  // separate receive and transmit flags.
  // Flags are sticky and cleared by writing a one; a new event in the clear cycle wins.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_stat_q <= usc_pkg::RST_IRQ;
      irq_mask_q <= usc_pkg::RST_IRQ;
    end else begin
      if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_q <= reg_wdata_i[1:0];
      end
      if (rx_ok) begin
        irq_stat_q[usc_pkg::IRQ_RX] <= 1'b1;
      end else if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_IRQ_STAT) &&
                   reg_wdata_i[usc_pkg::IRQ_RX]) begin
        irq_stat_q[usc_pkg::IRQ_RX] <= 1'b0;
      end
      if (tx_ok) begin
        irq_stat_q[usc_pkg::IRQ_TX] <= 1'b1;
      end else if (wr_hit(reg_we_i, reg_addr_i, usc_pkg::ADDR_IRQ_STAT) &&
                   reg_wdata_i[usc_pkg::IRQ_TX]) begin
        irq_stat_q[usc_pkg::IRQ_TX] <= 1'b0;
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  //////////////////////////////////////////////////////////////////////////////
  // DMA triggers.

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dma_rx_q <= 1'b0;
      dma_tx_q <= 1'b0;
    end else begin
      dma_rx_q <= rx_ok && dma_ok;
      dma_tx_q <= tx_ok && dma_ok;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read port.

  // five port registers plus interrupt pair.
  // Unmapped indices read zero; the flush bit always reads zero.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
    end else if (reg_re_i) begin
      case (reg_addr_i)
        usc_pkg::ADDR_CSR: rdata_q <= {csr_q[7:1], active_q};
        usc_pkg::ADDR_UCR: rdata_q <= {1'b0, ucr_q};
        usc_pkg::ADDR_GCR: rdata_q <= gcr_q;
        usc_pkg::ADDR_DBUF: rdata_q <= rx_buf_q;
        usc_pkg::ADDR_BAUD: rdata_q <= baud_q;
        usc_pkg::ADDR_IRQ_STAT: rdata_q <= {6'h00, irq_stat_q};
        usc_pkg::ADDR_IRQ_MASK: rdata_q <= {6'h00, irq_mask_q};
        default: rdata_q <= 8'h00;
      endcase
    end else begin
      rdata_q <= 8'h00;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign reg_rdata_o = rdata_q;
  assign tx_data_o = tx_buf_q;
  assign tx_load_o = tx_load_q;
  assign flush_o = flush_q;
  assign dma_rx_trig_o = dma_rx_q;
  assign dma_tx_trig_o = dma_tx_q;
  assign active_o = active_q;
  assign eng_ctrl_o = '{mode: csr_q[usc_pkg::CSR_MODE], rx_en: csr_q[usc_pkg::CSR_RX_EN],
                        slave: csr_q[usc_pkg::CSR_SLAVE], ucr: ucr_q, gcr: gcr_q,
                        baud: baud_q};

  //////////////////////////////////////////////////////////////////////////////
  // Assertions.

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // A byte accepted by the receive gate.
  sequence seq_rx_accept;
    eng_evt_i.rx_done && !flush_now && (!eng_ctrl_o.mode || eng_ctrl_o.rx_en);
  endsequence

  // A flush written to the asynchronous control register.
  sequence seq_flush;
    reg_we_i && reg_addr_i == usc_pkg::ADDR_UCR && reg_wdata_i[7];
  endsequence

  // A transmit complete event that no flush discards.
  sequence seq_tx_accept;
    eng_evt_i.tx_start && !flush_now;
  endsequence

  AST_FLUSH_CLEARS: assert property (seq_flush |=> rx_buf_q == 8'h00 && !active_o && flush_o)
    else $error("flush did not clear the buffer or activity");
  AST_FLUSH_READ0: assert property (reg_re_i && reg_addr_i == usc_pkg::ADDR_UCR |=> !reg_rdata_o[7])
    else $error("flush bit read back as one");
  AST_ACTIVE_DROP: assert property (seq_flush |=> !active_o ##1 !active_o)
    else $error("active stayed high after flush");
  AST_IRQ_RX: assert property (seq_rx_accept ##0 irq_mask_q[0] |=> irq_o && irq_stat_q[0])
    else $error("receive flag or request missing");
  AST_IRQ_GATE: assert property (irq_mask_q == 2'b00 |-> !irq_o)
    else $error("request raised with all enables clear");
  AST_DMA_RX: assert property (seq_rx_accept ##0 !gcr_q[6] |=> dma_rx_trig_o ##1 !dma_rx_trig_o)
    else $error("receive trigger not a single pulse");
  AST_DMA_CLOCK_PHASE_BIT: assert property (!eng_ctrl_o.mode && gcr_q[6] |=> !dma_tx_trig_o)
    else $error("trigger issued with clock phase one");
  AST_MODE_WR: assert property (wr_csr |=> eng_ctrl_o.mode == $past(reg_wdata_i[7]) &&
                                eng_ctrl_o.slave == $past(reg_wdata_i[5]))
    else $error("mode or slave bit not written");
  AST_RX_GATE: assert property (eng_evt_i.rx_done && eng_ctrl_o.mode && !eng_ctrl_o.rx_en
                                |=> !dma_rx_trig_o)
    else $error("byte accepted with receiver disabled");
  AST_FRAME: assert property (eng_evt_i.frame_err && !flush_now |=> csr_q[4])
    else $error("framing error not flagged");
  AST_PARITY: assert property (eng_evt_i.parity_err && !flush_now |=> csr_q[3])
    else $error("parity error not flagged");
  AST_RX_BYTE: assert property (seq_rx_accept |=> csr_q[2] && rx_buf_q == $past(eng_rx_data_i))
    else $error("received byte not ready");
  AST_TX_BYTE: assert property (eng_evt_i.tx_done && !flush_now |=> csr_q[1])
    else $error("transmitted flag not set");
  AST_ACTIVE: assert property (eng_evt_i.busy && !flush_now && !flush_o |=> active_o)
    else $error("busy engine not shown active");
  AST_W0_CLEAR: assert property (wr_csr && !reg_wdata_i[2] && !eng_evt_i.rx_done |=> !csr_q[2])
    else $error("written zero did not clear byte ready");

  // Further checks on flags, triggers and the buffer.
  // Both receive indications rise on the same edge.
  AST_RX_BOTH: assert property (seq_rx_accept |=>
                                irq_stat_q[usc_pkg::IRQ_RX] && csr_q[usc_pkg::CSR_RX_BYTE])
    else $error("receive flag and byte ready not raised together");
  // Transmit complete sets its own flag.
  AST_TX_FLAG: assert property (seq_tx_accept |=> irq_stat_q[usc_pkg::IRQ_TX])
    else $error("transmit flag not set");
  // Transmit trigger follows the event when the phase allows it.
  AST_DMA_TX: assert property (seq_tx_accept ##0 !gcr_q[usc_pkg::GCR_CLOCK_PHASE_BIT]
                               |=> dma_tx_trig_o)
    else $error("transmit trigger missing");
  // A written one clears the receive flag when no event competes.
  AST_IRQ_CLEAR: assert property (reg_we_i && reg_addr_i == usc_pkg::ADDR_IRQ_STAT &&
                                  reg_wdata_i[0] && !eng_evt_i.rx_done |=> !irq_stat_q[0])
    else $error("receive flag not cleared by a written one");
  // Flush leaves no received byte pending and an empty transmit half.
  AST_FLUSH_EMPTY: assert property (seq_flush |=> !csr_q[2] && tx_data_o == 8'h00)
    else $error("flush left data in the buffer");
  // Read data return to zero outside the answer cycle.
  AST_RDATA_IDLE: assert property (!reg_re_i |=> reg_rdata_o == 8'h00)
    else $error("read data stood outside the answer cycle");
  // A buffer write hands the byte to the engine with one load pulse.
  AST_TX_LOAD: assert property (reg_we_i && reg_addr_i == usc_pkg::ADDR_DBUF |=>
                                tx_load_o && tx_data_o == $past(reg_wdata_i))
    else $error("buffer write not handed to the engine");
  // A byte refused by the receiver gate leaves the buffer untouched.
  AST_RX_KEEP: assert property (eng_evt_i.rx_done && !eng_ctrl_o.rx_en &&
                                eng_ctrl_o.mode && !flush_now |=> $stable(rx_buf_q))
    else $error("refused byte reached the buffer");

endmodule

// File: testbench/usc_eng_model.sv
// Behavioural model of the serial shifting engine and its far-side peer.
module usc_eng_model #(
  parameter int BIT_CYC = 8  // Cycles in one bit period, kept short for the run.
) (
  input wire logic clk_i,                  // System clock.
  input wire logic resetn_i,               // Asynchronous reset, active low.
  input wire logic tx_load_i,              // New byte written to the buffer.
  input wire logic flush_i,                // Abort request.
  input wire logic rx_go_i,                // Peer starts sending a byte.
  input wire logic [7:0] rx_byte_i,        // Byte the peer sends.
  input wire logic rx_perr_i,              // Peer corrupts the parity.
  input wire logic rx_ferr_i,              // Peer sends a bad second stop bit.
  output usc_pkg::usc_evt_t evt_o,         // Events towards the block.
  output logic [7:0] rx_data_o             // Received byte, valid with rx_done.
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] st_q;    // 0 idle, 1 receiving, 2 second stop bit, 3 sending.
  logic [7:0] cnt_q;   // Bit period counter.
  logic [4:0] pls_q;   // Pulses: rx_done, parity, frame, tx_start, tx_done.
  logic [7:0] byte_q;  // Byte being received.
  logic ferr_q;        // Bad second stop bit pending.
  assign evt_o = '{pls_q[4], pls_q[3], pls_q[2], pls_q[1], pls_q[0], st_q != 2'h0};
  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer; data lines show a changing pattern outside rx_done so nothing stale passes.
  // stop bits, abort
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_q <= 2'h0;
      cnt_q <= 8'h00;
      pls_q <= 5'h00;
      byte_q <= 8'h00;
      ferr_q <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      pls_q <= 5'h00;
      rx_data_o <= ~rx_data_o;
      cnt_q <= cnt_q + 8'h01;
      if (flush_i) begin
        st_q <= 2'h0;
      end else if (tx_load_i) begin
        st_q <= 2'h3;
        cnt_q <= 8'h00;
        pls_q[1] <= 1'b1;
      end else if (rx_go_i) begin
        st_q <= 2'h1;
        cnt_q <= 8'h00;
        byte_q <= rx_byte_i;
        ferr_q <= rx_ferr_i;
        pls_q[3] <= rx_perr_i;
      end else if (st_q == 2'h1 && cnt_q == 8'(BIT_CYC)) begin
        pls_q[4] <= 1'b1;
        rx_data_o <= byte_q;
        cnt_q <= 8'h00;
        st_q <= ferr_q ? 2'h2 : 2'h0;
      end else if (st_q == 2'h2 && cnt_q == 8'(BIT_CYC)) begin
        pls_q[2] <= 1'b1;
        st_q <= 2'h0;
      end else if (st_q == 2'h3 && cnt_q == 8'(2 * BIT_CYC)) begin
        pls_q[0] <= 1'b1;
        st_q <= 2'h0;
      end
    end
  end
endmodule

// File: testbench/usc_ctrl_tb_top.sv
// Self-checking testbench of the serial control, status and interrupt block.
module usc_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic [7:0] exp;
  } usc_row_t;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [3:0] reg_addr_i = 4'h0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [7:0] reg_rdata_o, tx_data_o, eng_rx_data_i, rx_byte = 8'h00;
  logic tx_load_o, flush_o, irq_o, dma_rx_trig_o, dma_tx_trig_o, active_o;
  logic rx_go = 1'b0;
  logic rx_perr = 1'b0;
  logic rx_ferr = 1'b0;
  usc_pkg::usc_evt_t eng_evt_i;
  usc_pkg::usc_ctrl_t eng_ctrl_o;
  int bad_count = 0;
  int samples_checked = 0;
  int rx_trig_n = 0;  // Cycles seen with the receive trigger high.
  int tx_trig_n = 0;  // Cycles seen with the transmit trigger high.
  logic [7:0] rd_v;   // Data of the last register read.
  // Register map rows: reset values first, then write and read back.
  usc_row_t rows [14] = '{
    '{1'b0, 4'h0, 8'h00, 8'h00}, '{1'b0, 4'h1, 8'h00, 8'h02}, '{1'b0, 4'h2, 8'h00, 8'h00},
    '{1'b0, 4'h3, 8'h00, 8'h00}, '{1'b0, 4'h4, 8'h00, 8'h00}, '{1'b0, 4'h5, 8'h00, 8'h00},
    '{1'b0, 4'h6, 8'h00, 8'h00}, '{1'b0, 4'h7, 8'h00, 8'h00}, '{1'b1, 4'h0, 8'hff, 8'he0},
    '{1'b1, 4'h1, 8'h7f, 8'h7f}, '{1'b1, 4'h2, 8'ha5, 8'ha5}, '{1'b1, 4'h4, 8'h3c, 8'h3c},
    '{1'b1, 4'h6, 8'hff, 8'h03}, '{1'b1, 4'hf, 8'hff, 8'h00}};

  usc_ctrl #(.INSTANCE(0)) dut (.clk_i(clk_i), .resetn_i(resetn_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o), .eng_evt_i(eng_evt_i), .eng_rx_data_i(eng_rx_data_i),
    .eng_ctrl_o(eng_ctrl_o), .tx_data_o(tx_data_o), .tx_load_o(tx_load_o), .flush_o(flush_o),
    .irq_o(irq_o), .dma_rx_trig_o(dma_rx_trig_o), .dma_tx_trig_o(dma_tx_trig_o),
    .active_o(active_o));
  usc_eng_model #(.BIT_CYC(8)) peer (.clk_i(clk_i), .resetn_i(resetn_i),
    .tx_load_i(tx_load_o), .flush_i(flush_o), .rx_go_i(rx_go), .rx_byte_i(rx_byte),
    .rx_perr_i(rx_perr), .rx_ferr_i(rx_ferr), .evt_o(eng_evt_i), .rx_data_o(eng_rx_data_i));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock, and trigger pulse counters; a count per event proves one-cycle pulses.
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (dma_rx_trig_o === 1'b1) rx_trig_n++;
    if (dma_tx_trig_o === 1'b1) tx_trig_n++;
  end
  task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_we_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge clk_i);
    reg_we_i <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so it is taken there.
  task automatic rd(input logic [3:0] a);
    @(posedge clk_i);
    reg_re_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge clk_i);
    reg_re_i <= 1'b0;
    #1 rd_v = reg_rdata_o;
  endtask
  // The peer sends one byte, then the engine has ample time to finish.
  task automatic rx_send(input logic [7:0] b, input logic p, input logic f);
    @(posedge clk_i);
    rx_go <= 1'b1;
    rx_byte <= b;
    rx_perr <= p;
    rx_ferr <= f;
    @(posedge clk_i);
    rx_go <= 1'b0;
    repeat (40) @(posedge clk_i);
  endtask
  task automatic end_sim();
    if (bad_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    bad_count++;
    end_sim();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (4) @(posedge clk_i);
    resetn_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].wr) wr(rows[i].addr, rows[i].wdata);
      rd(rows[i].addr);
      check("register", rd_v, rows[i].exp);
    end
    check("baud out", eng_ctrl_o.baud, 8'h3c);
    // UART receive with parity and late framing error.
    wr(4'h0, 8'hc0);
    wr(4'h2, 8'h00);
    rx_send(8'h96, 1'b1, 1'b1);
    check("rx trig", 8'(rx_trig_n), 8'h01);
    rd(4'h0);
    check("csr errors", rd_v, 8'hdc);
    rd(4'h3);
    check("rx data", rd_v, 8'h96);
    rd(4'h5);
    check("irq stat", rd_v, 8'h01);
    check("irq on", 8'(irq_o), 8'h01);
    // Status flags clear by writing zero, interrupt flags by writing one.
    wr(4'h0, 8'hc0);
    rd(4'h0);
    check("csr clear", rd_v, 8'hc0);
    wr(4'h5, 8'h01);
    rd(4'h5);
    check("stat clear", rd_v, 8'h00);
    wr(4'h6, 8'h02);
    rx_send(8'h11, 1'b0, 1'b0);
    check("masked irq", 8'(irq_o), 8'h00);
    check("rx trig", 8'(rx_trig_n), 8'h02);
    // Receiver disabled in UART mode ignores the byte.
    wr(4'h5, 8'h01);
    wr(4'h0, 8'h80);
    rx_send(8'h22, 1'b0, 1'b0);
    rd(4'h0);
    check("rx off csr", rd_v, 8'h80);
    rd(4'h3);
    check("rx off data", rd_v, 8'h11);
    // Transmit: load pulse, busy, trigger, flag.
    wr(4'h3, 8'h3c);
    #1 check("tx data", tx_data_o, 8'h3c);
    check("tx load", 8'(tx_load_o), 8'h01);
    repeat (3) @(posedge clk_i);
    #1 check("active", 8'(active_o), 8'h01);
    repeat (40) @(posedge clk_i);
    check("tx trig", 8'(tx_trig_n), 8'h01);
    check("tx irq", 8'(irq_o), 8'h01);
    rd(4'h0);
    check("tx done", rd_v, 8'h82);
    // SPI with clock phase one: interrupt flag yes, trigger no.
    wr(4'h5, 8'h02);
    wr(4'h0, 8'h00);
    wr(4'h2, 8'h40);
    wr(4'h3, 8'h5a);
    repeat (40) @(posedge clk_i);
    check("no dma", 8'(tx_trig_n), 8'h01);
    rd(4'h5);
    check("clock_phase_bit stat", rd_v, 8'h02);
    // Abort in mid-transfer with a received byte waiting.
    wr(4'h2, 8'h00);
    rx_send(8'h77, 1'b0, 1'b0);
    wr(4'h3, 8'h01);
    repeat (4) @(posedge clk_i);
    wr(4'h1, 8'h82);
    #1 check("flush", 8'(flush_o), 8'h01);
    check("flush idle", 8'(active_o), 8'h00);
    @(posedge clk_i);
    #1 check("idle after", 8'(active_o), 8'h00);
    repeat (8) @(posedge clk_i);
    rd(4'h0);
    check("flush csr", rd_v & 8'h05, 8'h00);
    rd(4'h3);
    check("flush buf", rd_v, 8'h00);
    rd(4'h1);
    check("flush bit", rd_v, 8'h02);
    // Second reset in mid-run.
    @(posedge clk_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(4'h0);
    check("reset csr", rd_v, 8'h00);
    check("reset irq", 8'(irq_o), 8'h00);
    end_sim();
  end
endmodule
